/* design/mpt_defines.svh */
// Register map, field positions, reset values and timing counts
`ifndef MPT_DEFINES_SVH
`define MPT_DEFINES_SVH
// Register byte offsets
`define MPT_CTRL_OFS 8'h00
`define MPT_THERM_PICKUP_OFS 8'h04
`define MPT_THERM_TAU_OFS 8'h08
`define MPT_THERM_DELAY_OFS 8'h0C
`define MPT_THERM_MIN_OFS 8'h10
`define MPT_UC_THRESH_OFS 8'h14
`define MPT_UC_DELAY_OFS 8'h18
`define MPT_STOP_THRESH_OFS 8'h1C
`define MPT_OC_PICKUP_OFS 8'h20
`define MPT_OC_TIME_OFS 8'h24
`define MPT_STATUS_OFS 8'h28
`define MPT_THERM_IMAGE_OFS 8'h2C
// Control register fields
`define MPT_CTRL_WARN_BIT 0
`define MPT_CTRL_NOFLASH_BIT 1
`define MPT_CTRL_BRK_LSB 2
`define MPT_CTRL_CURVE_LSB 4
`define MPT_CTRL_LONGRST_BIT 7
`define MPT_CTRL_UCEN_BIT 8
`define MPT_CTRL_RST 16'h0000
// Thermal time constant fields
`define MPT_TAU_COOL_LSB 5
`define MPT_TAU_RST 16'h0048
// Reset values of settings
`define MPT_PICKUP_RST 16'h0100
`define MPT_DELAY_RST 16'h0064
`define MPT_OC_TIME_RST 16'h0064
// Overcurrent time setting bounds, 10 ms or 0.05 steps
`define MPT_DEFINITE_MIN 16'h0004
`define MPT_DEFINITE_MAX 16'h6590
`define MPT_TMS_MIN 16'h0001
`define MPT_TMS_MAX 16'h0190
// Inverse curve base times in 1/256 ticks per 0.05 multiplier
`define MPT_BASE_NI 32'h0000_0014
`define MPT_BASE_VI 32'h0000_0028
`define MPT_BASE_EI 32'h0000_0050
`define MPT_BASE_RI 32'h0000_000C
`define MPT_BASE_LI 32'h0000_00C8
// Timing: tick period, reset-mode hold and re-adjust window
`define MPT_CLK_NS 4
`define MPT_TICK_NS 10000000
`define MPT_TICK_CYC (`MPT_TICK_NS / `MPT_CLK_NS)
`define MPT_HOLD_S 60
`define MPT_READJ_S 300
`define MPT_HOLD_TICKS (`MPT_HOLD_S * 100)
`define MPT_READJ_TICKS (`MPT_READJ_S * 100)
`endif

/* design/mpt_pkg.sv */
// Types shared by the motor protection trip logic
package mpt_pkg;
  typedef enum logic [1:0] {
    MPT_STOP = 2'b00,
    MPT_START = 2'b01,
    MPT_RUNNING = 2'b10
  } mpt_mode_e;
  typedef enum logic [2:0] {
    MPT_DEFINITE_TIME_CURVE = 3'b000,
    MPT_NORMAL_INVERSE_CURVE = 3'b001,
    MPT_VERY_INVERSE_CURVE = 3'b010,
    MPT_EXTREMELY_INVERSE_CURVE = 3'b011,
    MPT_RI_INVERSE_CURVE = 3'b100,
    MPT_LONG_TERM_INVERSE_CURVE = 3'b101
  } mpt_curve_e;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } mpt_phase_s;
  typedef struct packed {
    logic trip;
    logic warn;
    logic trip_display;
  } mpt_relay_s;
  typedef struct packed {
    logic therm_exc;
    logic therm_flash;
    logic oc_red;
    logic oc_flash;
    logic oc_time_flash;
    logic oc_time_red;
    logic uc;
  } mpt_led_s;
endpackage : mpt_pkg

/* design/mpt_trip_logic.sv */
// Motor protection trip logic with AHB-Lite register slave
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "mpt_defines.svh"
module mpt_trip_logic
  import mpt_pkg::*;
#(
  parameter int TICK_CYC = `MPT_TICK_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire mpt_phase_s phase_current,
  input wire mpt_mode_e motor_mode,
  input wire logic reset_button_pin,
  output mpt_relay_s relay_out,
  output mpt_led_s led_out
);

  ////////////////////////////////////////////////////////////////////////
  // Settings and state
  logic [15:0] ctrl_reg, therm_pickup_reg, therm_tau_reg, therm_delay_reg;
  logic [15:0] therm_min_reg, uc_thresh_reg, uc_delay_reg, stop_reg;
  logic [15:0] oc_pickup_reg, oc_time_reg;
  logic [31:0] theta_reg;
  logic [15:0] exc_cnt_reg, brk_cnt_reg, uc_cnt_reg;
  logic [15:0] readj_cnt_reg, hold_cnt_reg;
  logic [31:0] oc_cnt_reg;
  logic exc_rec_reg, therm_flash_reg, therm_trip_reg, therm_warn_reg;
  logic uc_trip_reg, oc_trip_reg, oc_flash_reg, oc_picked_reg;
  logic oc_time_flash_reg;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [2:0] btn_sync_reg;
  logic btn_level_reg, btn_press;
  logic dp_wr_reg;
  logic [7:0] dp_addr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode helpers
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    reg_index = a[5:2];
  endfunction : reg_index

  // Zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end
    else if (hready)
    begin
      dp_wr_reg <= hsel & htrans[1] & hwrite;
      dp_addr_reg <= haddr[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tick divider and reset push-button synchroniser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tick_cnt_reg <= 32'h0000_0000;
    else if (tick)
      tick_cnt_reg <= 32'h0000_0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

  // Button counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      btn_sync_reg <= 3'h0;
      btn_level_reg <= 1'b0;
    end
    else
    begin
      btn_sync_reg <= {btn_sync_reg[1:0], reset_button_pin};
      if (btn_sync_reg[1] == btn_sync_reg[2])
        btn_level_reg <= btn_sync_reg[2];
    end
  end
  assign btn_press = (btn_sync_reg[1] == btn_sync_reg[2]) &
                     btn_sync_reg[2] & ~btn_level_reg;

  ////////////////////////////////////////////////////////////////////////
  // Current evaluation
  logic [15:0] imax, ab_max;
  logic [31:0] i_sq, lim_sq, diff, step;
  logic [4:0] shift;
  logic [2:0] curve;
  logic excite, brk_active, therm_hit, uc_cond, oc_fault, wr_time;
  logic [19:0] brk_level;
  logic [31:0] oc_limit, base;
  logic [2:0] band;
  assign ab_max = (phase_current.a > phase_current.b) ?
                  phase_current.a : phase_current.b;
  assign imax = (ab_max > phase_current.c) ? ab_max : phase_current.c;
  assign i_sq = 32'(imax) * 32'(imax);
  assign lim_sq = 32'(therm_pickup_reg) * 32'(therm_pickup_reg);
  assign excite = imax > therm_pickup_reg;
  assign curve = ctrl_reg[`MPT_CTRL_CURVE_LSB +: 3];
  assign wr_time = dp_wr_reg &&
                   dp_addr_reg == `MPT_OC_TIME_OFS;

  always_comb
  begin
    case (ctrl_reg[`MPT_CTRL_BRK_LSB +: 2])
      2'b01: brk_level = {3'h0, therm_pickup_reg, 1'b0};
      2'b10: brk_level = {2'h0, therm_pickup_reg, 2'h0} +
                         {3'h0, therm_pickup_reg, 1'b0};
      default: brk_level = 20'hF_FFFF;
    endcase
  end
  assign brk_active = motor_mode == MPT_START &&
                      ctrl_reg[`MPT_CTRL_BRK_LSB +: 2] != 2'b00 &&
                      {4'h0, imax} > brk_level;

  // cooling uses tau plus cooling factor shift
  always_comb
  begin
    if (i_sq >= theta_reg)
    begin
      diff = i_sq - theta_reg;
      shift = therm_tau_reg[4:0];
    end
    else
    begin
      diff = theta_reg - i_sq;
      shift = therm_tau_reg[4:0] +
              therm_tau_reg[`MPT_TAU_COOL_LSB +: 5];
    end
    step = diff >> shift;
    if (step == 32'h0000_0000 && diff != 32'h0000_0000)
      step = 32'h0000_0001;
  end

  assign therm_hit = (lim_sq != 32'h0000_0000 && theta_reg >= lim_sq) ||
                     (brk_active && brk_cnt_reg >= therm_min_reg);

  ////////////////////////////////////////////////////////////////////////
  // Thermal image
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      theta_reg <= 32'h0000_0000;
    else if (tick && !brk_active)
    begin
      if (i_sq >= theta_reg)
        theta_reg <= theta_reg + step;
      else
        theta_reg <= theta_reg - step;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      brk_cnt_reg <= 16'h0000;
    else if (!brk_active)
      brk_cnt_reg <= 16'h0000;
    else if (tick && brk_cnt_reg != 16'hFFFF)
      brk_cnt_reg <= brk_cnt_reg + 16'h0001;
  end

  // warning or trip on thermal limit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      therm_trip_reg <= 1'b0;
      therm_warn_reg <= 1'b0;
    end
    else
    begin
      if (therm_hit && !ctrl_reg[`MPT_CTRL_WARN_BIT])
        therm_trip_reg <= 1'b1;
      else if (btn_press)
        therm_trip_reg <= 1'b0;
      therm_warn_reg <= therm_hit && ctrl_reg[`MPT_CTRL_WARN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      exc_cnt_reg <= 16'h0000;
      exc_rec_reg <= 1'b0;
    end
    else if (!excite)
    begin
      exc_cnt_reg <= 16'h0000;
      exc_rec_reg <= 1'b0;
    end
    else if (exc_cnt_reg >= therm_delay_reg)
      exc_rec_reg <= 1'b1;
    else if (tick)
      exc_cnt_reg <= exc_cnt_reg + 16'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      therm_flash_reg <= 1'b0;
    else if (exc_rec_reg && !excite && !therm_trip_reg &&
             !ctrl_reg[`MPT_CTRL_NOFLASH_BIT])
      therm_flash_reg <= 1'b1;
    else if (btn_press)
      therm_flash_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Undercurrent element
  // running only, enable bit
  assign uc_cond = ctrl_reg[`MPT_CTRL_UCEN_BIT] &&
                   motor_mode == MPT_RUNNING &&
                   imax >= stop_reg && imax < uc_thresh_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      uc_cnt_reg <= 16'h0000;
      uc_trip_reg <= 1'b0;
    end
    else
    begin
      if (!uc_cond)
        uc_cnt_reg <= 16'h0000;
      else if (tick && uc_cnt_reg != 16'hFFFF)
        uc_cnt_reg <= uc_cnt_reg + 16'h0001;
      if (uc_cond && uc_cnt_reg >= uc_delay_reg)
        uc_trip_reg <= 1'b1;
      else if (btn_press)
        uc_trip_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overcurrent element
  // running only
  assign oc_fault = motor_mode == MPT_RUNNING && imax > oc_pickup_reg;

  // Current multiple band for inverse curves
  always_comb
  begin
    if ({4'h0, imax} >= {oc_pickup_reg, 4'h0})
      band = 3'd4;
    else if ({4'h0, imax} >= {1'b0, oc_pickup_reg, 3'h0})
      band = 3'd3;
    else if ({4'h0, imax} >= {2'h0, oc_pickup_reg, 2'h0})
      band = 3'd2;
    else if ({4'h0, imax} >= {3'h0, oc_pickup_reg, 1'b0})
      band = 3'd1;
    else
      band = 3'd0;
  end

  always_comb
  begin
    case (curve)
      MPT_NORMAL_INVERSE_CURVE: base = `MPT_BASE_NI << band;
      MPT_VERY_INVERSE_CURVE: base = `MPT_BASE_VI << band;
      MPT_EXTREMELY_INVERSE_CURVE: base = `MPT_BASE_EI << (band * 2);
      MPT_RI_INVERSE_CURVE: base = `MPT_BASE_RI << band;
      MPT_LONG_TERM_INVERSE_CURVE: base = `MPT_BASE_LI << band;
      default: base = 32'h0000_0001;
    endcase
    oc_limit = base * {16'h0000, oc_time_reg};
    if (curve != MPT_DEFINITE_TIME_CURVE)
      oc_limit = oc_limit >> 8;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      oc_cnt_reg <= 32'h0000_0000;
      hold_cnt_reg <= 16'h0000;
    end
    else if (oc_fault)
    begin
      hold_cnt_reg <= 16'h0000;
      if (tick && oc_cnt_reg < oc_limit)
        oc_cnt_reg <= oc_cnt_reg + 32'h0000_0001;
    end
    else if (!ctrl_reg[`MPT_CTRL_LONGRST_BIT])
      oc_cnt_reg <= 32'h0000_0000;
    else if (hold_cnt_reg >= 16'(`MPT_HOLD_TICKS))
    begin
      oc_cnt_reg <= 32'h0000_0000;
      hold_cnt_reg <= 16'h0000;
    end
    else if (tick && oc_cnt_reg != 32'h0000_0000)
      hold_cnt_reg <= hold_cnt_reg + 16'h0001;
  end

  // infinite setting blocks trip, trip at limit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      oc_trip_reg <= 1'b0;
    else if (oc_fault && oc_time_reg != 16'h0000 &&
             oc_cnt_reg >= oc_limit)
      oc_trip_reg <= 1'b1;
    else if (btn_press)
      oc_trip_reg <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      oc_picked_reg <= 1'b0;
      oc_flash_reg <= 1'b0;
    end
    else
    begin
      oc_picked_reg <= oc_fault;
      if (oc_picked_reg && !oc_fault && !oc_trip_reg &&
          !ctrl_reg[`MPT_CTRL_NOFLASH_BIT])
        oc_flash_reg <= 1'b1;
      else if (btn_press)
        oc_flash_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  function automatic logic [15:0] clamp_time(input logic [15:0] v,
                                             input logic [2:0] c);
    logic [15:0] lo, hi;
    lo = (c == MPT_DEFINITE_TIME_CURVE) ? `MPT_DEFINITE_MIN : `MPT_TMS_MIN;
    hi = (c == MPT_DEFINITE_TIME_CURVE) ? `MPT_DEFINITE_MAX : `MPT_TMS_MAX;
    if (v == 16'h0000)
      clamp_time = v;
    else if (v < lo)
      clamp_time = lo;
    else if (v > hi)
      clamp_time = hi;
    else
      clamp_time = v;
  endfunction : clamp_time

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= `MPT_CTRL_RST;
      therm_pickup_reg <= `MPT_PICKUP_RST;
      therm_tau_reg <= `MPT_TAU_RST;
      therm_delay_reg <= `MPT_DELAY_RST;
      therm_min_reg <= `MPT_DELAY_RST;
      uc_thresh_reg <= 16'h0000;
      uc_delay_reg <= `MPT_DELAY_RST;
      stop_reg <= 16'h0000;
      oc_pickup_reg <= `MPT_PICKUP_RST;
      oc_time_reg <= `MPT_OC_TIME_RST;
    end
    else if (dp_wr_reg)
    begin
      case (reg_index(dp_addr_reg))
        reg_index(`MPT_CTRL_OFS): ctrl_reg <= {7'h00, hwdata[8:0]};
        reg_index(`MPT_THERM_PICKUP_OFS): therm_pickup_reg <= hwdata[15:0];
        reg_index(`MPT_THERM_TAU_OFS): therm_tau_reg <= {6'h00, hwdata[9:0]};
        reg_index(`MPT_THERM_DELAY_OFS): therm_delay_reg <= hwdata[15:0];
        reg_index(`MPT_THERM_MIN_OFS): therm_min_reg <= hwdata[15:0];
        reg_index(`MPT_UC_THRESH_OFS): uc_thresh_reg <= hwdata[15:0];
        reg_index(`MPT_UC_DELAY_OFS): uc_delay_reg <= hwdata[15:0];
        reg_index(`MPT_STOP_THRESH_OFS): stop_reg <= hwdata[15:0];
        reg_index(`MPT_OC_PICKUP_OFS): oc_pickup_reg <= hwdata[15:0];
        reg_index(`MPT_OC_TIME_OFS):
          oc_time_reg <= clamp_time(hwdata[15:0], curve);
        default: ;
      endcase
    end
    else if (oc_time_flash_reg &&
             readj_cnt_reg >= 16'(`MPT_READJ_TICKS))
      oc_time_reg <= (curve == MPT_DEFINITE_TIME_CURVE) ?
                     `MPT_DEFINITE_MIN : `MPT_TMS_MIN;
  end

  // flash after curve change until re-adjusted or the re-adjust window ends
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      oc_time_flash_reg <= 1'b0;
      readj_cnt_reg <= 16'h0000;
    end
    else if (dp_wr_reg && dp_addr_reg == `MPT_CTRL_OFS &&
             hwdata[`MPT_CTRL_CURVE_LSB +: 3] != curve)
    begin
      oc_time_flash_reg <= 1'b1;
      readj_cnt_reg <= 16'h0000;
    end
    else if (wr_time || (oc_time_flash_reg &&
             readj_cnt_reg >= 16'(`MPT_READJ_TICKS)))
      oc_time_flash_reg <= 1'b0;
    else if (oc_time_flash_reg && tick)
      readj_cnt_reg <= readj_cnt_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered at address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      case (reg_index(haddr[7:0]))
        reg_index(`MPT_CTRL_OFS): hrdata <= {16'h0000, ctrl_reg};
        reg_index(`MPT_THERM_PICKUP_OFS):
          hrdata <= {16'h0000, therm_pickup_reg};
        reg_index(`MPT_THERM_TAU_OFS): hrdata <= {16'h0000, therm_tau_reg};
        reg_index(`MPT_THERM_DELAY_OFS): hrdata <= {16'h0000, therm_delay_reg};
        reg_index(`MPT_THERM_MIN_OFS): hrdata <= {16'h0000, therm_min_reg};
        reg_index(`MPT_UC_THRESH_OFS): hrdata <= {16'h0000, uc_thresh_reg};
        reg_index(`MPT_UC_DELAY_OFS): hrdata <= {16'h0000, uc_delay_reg};
        reg_index(`MPT_STOP_THRESH_OFS): hrdata <= {16'h0000, stop_reg};
        reg_index(`MPT_OC_PICKUP_OFS): hrdata <= {16'h0000, oc_pickup_reg};
        reg_index(`MPT_OC_TIME_OFS): hrdata <= {16'h0000, oc_time_reg};
        reg_index(`MPT_STATUS_OFS):
          hrdata <= {22'h00_0000, motor_mode, 1'b0, oc_fault, excite,
                     oc_time_flash_reg, therm_warn_reg, oc_trip_reg,
                     uc_trip_reg, therm_trip_reg};
        reg_index(`MPT_THERM_IMAGE_OFS): hrdata <= theta_reg;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Relay and LED drives
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      relay_out <= '0;
      led_out <= '0;
    end
    else
    begin
      relay_out.trip <= therm_trip_reg | uc_trip_reg | oc_trip_reg;
      relay_out.warn <= therm_warn_reg | exc_rec_reg |
                        (oc_fault && oc_time_reg == 16'h0000);
      relay_out.trip_display <= therm_trip_reg | uc_trip_reg | oc_trip_reg;
      led_out.therm_exc <= excite;
      led_out.therm_flash <= therm_flash_reg;
      led_out.oc_red <= oc_fault | oc_trip_reg |
                        (oc_time_reg == 16'h0000);
      led_out.oc_time_red <= oc_time_reg == 16'h0000;
      led_out.oc_flash <= oc_flash_reg;
      led_out.oc_time_flash <= oc_time_flash_reg;
      led_out.uc <= uc_trip_reg;
    end
  end

endmodule : mpt_trip_logic

/* verif/mpt_trip_monitor.sv */
// Port checker for the motor protection trip logic
`timescale 1ns/1ps
module mpt_trip_monitor
  import mpt_pkg::*;
#(
  parameter int TICK_CYC = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire mpt_mode_e motor_mode,
  input wire logic reset_button_pin,
  input wire mpt_relay_s relay_out,
  input wire mpt_led_s led_out
);
  logic [3:0] btn_age_reg;
  // Cycles since the reset button was last high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      btn_age_reg <= 4'hF;
    else if (reset_button_pin)
      btn_age_reg <= 4'h0;
    else if (btn_age_reg != 4'hF)
      btn_age_reg <= btn_age_reg + 4'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase taken
  sequence rd_taken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  ready_high_a: assert property (hreadyout)
    else $error("hreadyout low");
  okay_resp_a: assert property (!hresp)
    else $error("hresp not okay");
  reset_quiet_a: assert property ($rose(hresetn) |->
    relay_out == 3'b000 && led_out == 7'h00)
    else $error("outputs set at reset exit");
  rd_upper_a: assert property (rd_taken ##0 (haddr[5:2] != 4'hB) |=>
    hrdata[31:16] == 16'h0000) else $error("upper read bits set");
  display_trip_a: assert property (
    relay_out.trip_display |-> relay_out.trip)
    else $error("trip shown without trip relay");
  trip_latch_a: assert property (
    $fell(relay_out.trip) |-> btn_age_reg < 4'hA)
    else $error("trip dropped without button");
  red_pair_a: assert property (
    led_out.oc_time_red |-> led_out.oc_red)
    else $error("time led red alone");
  uc_running_a: assert property (
    $rose(led_out.uc) |-> $past(motor_mode, 2) == MPT_RUNNING)
    else $error("undercurrent outside running");
  uc_trip_a: assert property (
    led_out.uc |-> relay_out.trip) else $error("uc led without trip");
endmodule : mpt_trip_monitor

/* verif/mpt_front_end.sv */
// Current measurement front end model
`timescale 1ns/1ps
module mpt_front_end
  import mpt_pkg::*;
(
  input wire logic hclk,
  input wire logic [15:0] level,
  input wire mpt_mode_e mode,
  output mpt_phase_s phase_current,
  output mpt_mode_e motor_mode
);
  // Phase b carries the level, others stay below it
  always_ff @(posedge hclk)
  begin
    phase_current <= '{a: level >> 1, b: level, c: level >> 2};
    motor_mode <= mode;
  end
endmodule : mpt_front_end

/* verif/motor_protection_trip_logic_bench.sv */
// Self-checking bench for the motor protection trip logic
`timescale 1ns/1ps
module motor_protection_trip_logic_bench;
  import mpt_pkg::*;
  localparam int TICK_CYC = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, btn;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] level;
  mpt_mode_e mode, motor_mode;
  mpt_phase_s phase_current;
  mpt_relay_s relay_out;
  mpt_led_s led_out;
  int failures, check_count, n;
  assign hready = hreadyout;
  mpt_trip_logic #(.TICK_CYC(TICK_CYC)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .phase_current(phase_current),
    .motor_mode(motor_mode), .reset_button_pin(btn),
    .relay_out(relay_out), .led_out(led_out));
  mpt_front_end fe (.hclk(hclk), .level(level), .mode(mode),
    .phase_current(phase_current), .motor_mode(motor_mode));
  // Bus clock
  always #2 hclk = ~hclk;
  // One single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    q = hrdata;
  endtask : bus
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] v);
    check_count++;
    if (v !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk("register", e, q);
  endtask : rdc
  task automatic go(input mpt_mode_e m, input logic [15:0] l, input int c);
    mode <= m;
    level <= l;
    repeat (c) @(posedge hclk);
  endtask : go
  // Remove the fault and press the reset button
  task automatic clr();
    go(MPT_STOP, 16'h0000, 4);
    btn <= 1'b1;
    repeat (6) @(posedge hclk);
    btn <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask : clr
  task automatic regs_test();
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h04, 32'h0000_0100);
    rdc(8'h08, 32'h0000_0048);
    rdc(8'h24, 32'h0000_0064);
    bus(1'b1, 8'h24, 32'h0000_0001);
    rdc(8'h24, 32'h0000_0004);
    bus(1'b1, 8'h28, 32'h0000_FFFF);
    rdc(8'h28, 32'h0000_0000);
    bus(1'b1, 8'h30, 32'h0000_FFFF);
    rdc(8'h30, 32'h0000_0000);
    bus(1'b1, 8'h04, 32'h0000_FFFF);
  endtask : regs_test
  task automatic curve_test();
    for (int c = 1; c <= 6; c++)
    begin
      bus(1'b1, 8'h00, 32'((c % 6) << 4));
      rdc(8'h00, 32'((c % 6) << 4));
      repeat (3) @(posedge hclk);
      chk("time flash on", 1, led_out.oc_time_flash);
      bus(1'b1, 8'h24, 32'h0000_FFFF);
      rdc(8'h24, (c < 6) ? 32'h0000_0190 : 32'h0000_6590);
      repeat (3) @(posedge hclk);
      chk("time flash off", 0, led_out.oc_time_flash);
    end
  endtask : curve_test
  task automatic oc_test();
    bus(1'b1, 8'h24, 32'h0000_000A);
    go(MPT_START, 16'h0200, 80);
    chk("trip in start", 0, relay_out.trip);
    go(MPT_RUNNING, 16'h0200, 0);
    n = 0;
    while (relay_out.trip !== 1'b1 && n < 200)
    begin
      @(posedge hclk);
      n++;
    end
    chk("oc delay", 1, n >= 33 && n <= 50);
    chk("trip shown", 1, relay_out.trip_display);
    rdc(8'h28, 32'h0000_0244);
    clr();
    bus(1'b1, 8'h24, 32'h0000_0000);
    go(MPT_RUNNING, 16'h0200, 200);
    chk("blocked trip", 0, relay_out.trip);
    chk("alarm", 1, relay_out.warn);
    chk("oc red", 1, led_out.oc_red);
    chk("time red", 1, led_out.oc_time_red);
    go(MPT_STOP, 16'h0000, 4);
    chk("oc flash", 1, led_out.oc_flash);
    clr();
    chk("flash cleared", 0, led_out.oc_flash);
  endtask : oc_test
  task automatic burst(input logic [31:0] ctrl, input logic e);
    bus(1'b1, 8'h00, ctrl);
    bus(1'b1, 8'h24, 32'h0000_0014);
    go(MPT_RUNNING, 16'h0200, 60);
    go(MPT_RUNNING, 16'h0000, 12);
    go(MPT_RUNNING, 16'h0200, 60);
    chk("burst trip", e, relay_out.trip);
    chk("burst flash", e, led_out.oc_flash);
    clr();
  endtask : burst
  task automatic uc_test();
    bus(1'b1, 8'h00, 32'h0000_0100);
    bus(1'b1, 8'h14, 32'h0000_0080);
    bus(1'b1, 8'h18, 32'h0000_000A);
    bus(1'b1, 8'h1C, 32'h0000_0010);
    go(MPT_START, 16'h0040, 20);
    go(MPT_RUNNING, 16'h0008, 200);
    chk("uc below stop", 0, led_out.uc);
    go(MPT_RUNNING, 16'h0040, 80);
    chk("uc led", 1, led_out.uc);
    chk("uc trip", 1, relay_out.trip);
    clr();
  endtask : uc_test
  task automatic therm_test();
    // Empty the image so earlier heating is forgotten
    bus(1'b1, 8'h08, 32'h0000_0000);
    go(MPT_STOP, 16'h0000, 12);
    rdc(8'h2C, 32'h0000_0000);
    bus(1'b1, 8'h08, 32'h0000_0048);
    bus(1'b1, 8'h00, 32'h0000_0001);
    bus(1'b1, 8'h04, 32'h0000_0100);
    go(MPT_START, 16'h0200, 5);
    chk("exc led", 1, led_out.therm_exc);
    chk("early warn", 0, relay_out.warn);
    go(MPT_START, 16'h0000, 8);
    chk("early flash", 0, led_out.therm_flash);
    go(MPT_START, 16'h0200, 700);
    bus(1'b0, 8'h28, 32'h0000_0000);
    chk("therm warn", 1, q[3]);
    chk("warn relay", 1, relay_out.warn);
    chk("no trip", 0, relay_out.trip);
    chk("no display", 0, relay_out.trip_display);
    go(MPT_STOP, 16'h0000, 8);
    chk("therm flash", 1, led_out.therm_flash);
    bus(1'b1, 8'h00, 32'h0000_0000);
    repeat (10) @(posedge hclk);
    chk("therm trip", 1, relay_out.trip);
  endtask : therm_test
  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    btn = 1'b0;
    level = 16'h0000;
    mode = MPT_STOP;
    failures = 0;
    check_count = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    regs_test();
    curve_test();
    oc_test();
    burst(32'h0000_0002, 1'b0);
    burst(32'h0000_0080, 1'b1);
    uc_test();
    therm_test();
    print_verdict();
  end
  // Watchdog
  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule : motor_protection_trip_logic_bench
bind mpt_trip_logic mpt_trip_monitor #(.TICK_CYC(TICK_CYC)) mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .motor_mode(motor_mode), .reset_button_pin(reset_button_pin),
  .relay_out(relay_out), .led_out(led_out));
